// file: pcthb_header_bank.sv
`timescale 1ns/1ns
module pcthb_header_bank (
	input logic mclk,
	input logic rst_b,
	input logic [7:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input pcthb_pkg::pcthb_cfgreq_s cfgReq,
	output logic [31:0] cfgRdData,
	output logic cfgDone,
	input pcthb_pkg::pcthb_probe_s probe,
	output logic [6:0] probeHit,
	output logic probeHitValid
);
	logic [31:0] setWord [pcthb_pkg::PCTHB_NUM_SET];
	logic avAck;
	logic avSet;
	logic avStat;
	logic [2:0] avIdx;
	logic [31:0] avValue;
	logic [15:0] subsys;
	logic [2:0] irqPin;
	logic [2:0] pinShown;
	logic [7:0] irqLine;
	logic [7:0] selfTest;
	logic [7:0] capPtr;
	logic [7:0] vfCapPtr;
	logic romEnable;
	logic [4:0] romSize;
	logic rootMode;
	logic [31:0] winValue [pcthb_pkg::PCTHB_NUM_WIN];
	logic [5:0] winHit;
	logic [31:0] romValue;
	logic romHit;
	logic [31:0] hdrWord;
	logic cfgWr;
	logic cfgRd;
	logic [6:0] lastHit;
	logic [7:0] claimCount;

	// One wait state on every access keeps read data straight from a flop
	assign avs_waitrequest = (avs_read | avs_write) & ~avAck;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			avAck <= 1'b0;
		else
			avAck <= (avs_read | avs_write) & ~avAck;
	end

	always_comb
	begin
		avIdx = pcthb_pkg::PCTHB_IX_SUBSYS;
		avSet = 1'b0;
		avStat = 1'b0;
		if (avs_address == pcthb_pkg::PCTHB_AV_SUBSYS)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_SUBSYS;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_IRQ)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_IRQ;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_BIST)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_BIST;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_CAP)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_CAP;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_TYPE)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_TYPE;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_SIZE)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_SIZE;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_MODE)
		begin
			avIdx = pcthb_pkg::PCTHB_IX_MODE;
			avSet = 1'b1;
		end
		else if (avs_address == pcthb_pkg::PCTHB_AV_STATUS)
			avStat = 1'b1;
	end

	always_comb
	begin
		avValue = 32'h0;
		if (avSet)
			avValue = setWord[avIdx];
		else if (avStat)
			avValue = 32'(lastHit) | (32'(claimCount) << pcthb_pkg::PCTHB_COUNT_LSB);
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			avs_readdata <= 32'h0;
		else if (avs_read && !avAck)
			avs_readdata <= avValue;
	end

	// Writes land only at the edge after the wait, with waitrequest low; unmapped ones are dropped
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < pcthb_pkg::PCTHB_NUM_SET; i++)
				setWord[i] <= pcthb_pkg::PCTHB_RST[i];
		end
		else if (avs_write && avAck && avSet)
			setWord[avIdx] <= pcthb_pkg::byteMerge(setWord[avIdx], avs_writedata,
				avs_byteenable) & pcthb_pkg::PCTHB_IMPL[avIdx];
	end

	assign subsys = setWord[pcthb_pkg::PCTHB_IX_SUBSYS][15:0];
	assign irqPin = setWord[pcthb_pkg::PCTHB_IX_IRQ][2:0];
	assign irqLine = setWord[pcthb_pkg::PCTHB_IX_IRQ][pcthb_pkg::PCTHB_LINE_LSB +: 8];
	assign selfTest = setWord[pcthb_pkg::PCTHB_IX_BIST][7:0];
	assign capPtr = setWord[pcthb_pkg::PCTHB_IX_CAP][7:0];
	assign vfCapPtr = setWord[pcthb_pkg::PCTHB_IX_CAP][pcthb_pkg::PCTHB_VFCAP_LSB +: 8];
	assign romEnable = setWord[pcthb_pkg::PCTHB_IX_MODE][0];
	assign romSize = setWord[pcthb_pkg::PCTHB_IX_MODE][pcthb_pkg::PCTHB_ROMSIZE_LSB +: 5];
	assign rootMode = setWord[pcthb_pkg::PCTHB_IX_MODE][pcthb_pkg::PCTHB_ROOT_LSB];
	// Out-of-range pin settings show as no legacy interrupt
	assign pinShown = (irqPin <= pcthb_pkg::PCTHB_PIN_MAX) ? irqPin : 3'h0;

	// Virtual functions own no header windows, so their writes are dropped
	assign cfgWr = cfgReq.valid & cfgReq.write & ~cfgReq.virtualFn;
	assign cfgRd = cfgReq.valid & ~cfgReq.write;

	for (genvar p = 0; p < pcthb_pkg::PCTHB_NUM_PAIRS; p++)
	begin : gPair
		pcthb_window_pair uPair (
			.mclk(mclk),
			.rst_b(rst_b),
			.rootPort(p == 0 ? rootMode : 1'b0),
			.loType(setWord[pcthb_pkg::PCTHB_IX_TYPE][2 * p * pcthb_pkg::PCTHB_TYPE_W +: 3]),
			.hiType(setWord[pcthb_pkg::PCTHB_IX_TYPE][(2 * p + 1) * pcthb_pkg::PCTHB_TYPE_W +: 3]),
			.loSize(setWord[pcthb_pkg::PCTHB_IX_SIZE][2 * p * pcthb_pkg::PCTHB_SIZE_W +: 5]),
			.hiSize(setWord[pcthb_pkg::PCTHB_IX_SIZE][(2 * p + 1) * pcthb_pkg::PCTHB_SIZE_W +: 5]),
			.wrLo(cfgWr && cfgReq.dword == 4'(pcthb_pkg::PCTHB_DW_BAR0 + 2 * p)),
			.wrHi(cfgWr && cfgReq.dword == 4'(pcthb_pkg::PCTHB_DW_BAR0 + 2 * p + 1)),
			.wrData(cfgReq.data),
			.byteEn(cfgReq.byteEn),
			.loValue(winValue[2 * p]),
			.hiValue(winValue[2 * p + 1]),
			.probe(probe),
			.hitLo(winHit[2 * p]),
			.hitHi(winHit[2 * p + 1])
		);
	end

	pcthb_rom_window uRom (
		.mclk(mclk),
		.rst_b(rst_b),
		.enable(romEnable),
		.sizeCode(romSize),
		.wr(cfgWr && cfgReq.dword == pcthb_pkg::PCTHB_DW_ROM),
		.wrData(cfgReq.data),
		.byteEn(cfgReq.byteEn),
		.value(romValue),
		.probe(probe),
		.hit(romHit)
	);

	always_comb
	begin
		hdrWord = 32'h0;
		if (cfgReq.dword == pcthb_pkg::PCTHB_DW_BIST)
		begin
			if (!cfgReq.virtualFn)
				hdrWord[pcthb_pkg::PCTHB_BIST_LSB +: 8] = selfTest;
		end
		else if (cfgReq.dword >= pcthb_pkg::PCTHB_DW_BAR0 && cfgReq.dword <= pcthb_pkg::PCTHB_DW_BAR5)
		begin
			if (!cfgReq.virtualFn)
				hdrWord = winValue[3'(cfgReq.dword - pcthb_pkg::PCTHB_DW_BAR0)];
		end
		else if (cfgReq.dword == pcthb_pkg::PCTHB_DW_SUBSYS)
			hdrWord[pcthb_pkg::PCTHB_SUBSYS_LSB +: 16] = subsys;
		else if (cfgReq.dword == pcthb_pkg::PCTHB_DW_ROM)
		begin
			if (!cfgReq.virtualFn)
				hdrWord = romValue;
		end
		else if (cfgReq.dword == pcthb_pkg::PCTHB_DW_CAP)
			hdrWord[7:0] = cfgReq.virtualFn ? vfCapPtr : capPtr;
		else if (cfgReq.dword == pcthb_pkg::PCTHB_DW_INT)
		begin
			if (!cfgReq.virtualFn)
			begin
				hdrWord[pcthb_pkg::PCTHB_PIN_LSB +: 8] = {5'h00, pinShown};
				hdrWord[7:0] = irqLine;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			cfgDone <= 1'b0;
		else
			cfgDone <= cfgReq.valid;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			cfgRdData <= 32'h0;
		else if (cfgRd)
			cfgRdData <= hdrWord;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			probeHit <= 7'h00;
			probeHitValid <= 1'b0;
		end
		else
		begin
			probeHit <= probe.valid ? {romHit, winHit} : 7'h00;
			probeHitValid <= probe.valid;
		end
	end

	// Status keeps the claim pattern of the last probe, zero on a miss; the count wraps silently
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			lastHit <= 7'h00;
		else if (probe.valid)
			lastHit <= {romHit, winHit};
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			claimCount <= 8'h00;
		else if (probe.valid && ({romHit, winHit} != 7'h00))
			claimCount <= claimCount + 8'h01;
	end

	bus_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access waited more than one cycle");
	subsys_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cfgRd && cfgReq.dword == pcthb_pkg::PCTHB_DW_SUBSYS
		|=> cfgDone && cfgRdData[31:16] == $past(subsys) && cfgRdData[15:0] == 16'h0)
		else $error("subsystem code read wrong");
	irq_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cfgRd && !cfgReq.virtualFn && cfgReq.dword == pcthb_pkg::PCTHB_DW_INT
		|=> cfgRdData[15:8] == (($past(irqPin) > pcthb_pkg::PCTHB_PIN_MAX) ? 8'h00 :
		{5'h00, $past(irqPin)}))
		else $error("interrupt pin read wrong");
	irq_line_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cfgRd && !cfgReq.virtualFn && cfgReq.dword == pcthb_pkg::PCTHB_DW_INT
		|=> cfgRdData[7:0] == $past(irqLine))
		else $error("interrupt line read wrong");
	vf_int_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cfgRd && cfgReq.virtualFn && cfgReq.dword == pcthb_pkg::PCTHB_DW_INT |=> cfgRdData == 32'h0)
		else $error("virtual function shows interrupt settings");
	self_test_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cfgRd && cfgReq.dword == pcthb_pkg::PCTHB_DW_BIST
		|=> cfgRdData[31:24] == ($past(cfgReq.virtualFn) ? 8'h00 : $past(selfTest)))
		else $error("self-test byte read wrong");
	cap_ptr_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cfgRd && cfgReq.dword == pcthb_pkg::PCTHB_DW_CAP
		|=> cfgRdData[7:0] == ($past(cfgReq.virtualFn) ? $past(vfCapPtr) : $past(capPtr)))
		else $error("capability pointer read wrong");
	rom_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!romEnable && probe.valid |=> !probeHit[6] && (lastHit[6] == 1'b0))
		else $error("disabled option ROM window claimed");
endmodule

// file: pcthb_header_bank_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module pcthb_header_bank_tb;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	pcthb_pkg::pcthb_cfgreq_s cfgReq;
	logic [31:0] cfgRdData;
	logic cfgDone;
	pcthb_pkg::pcthb_probe_s probe;
	logic [6:0] probeHit;
	logic probeHitValid;
	int mismatches = 0;
	int compares = 0;
	logic [31:0] wt [8] = '{32'h0, 32'hffffff81, 32'h0, 32'h0, 32'hffffff80, 32'hffffff88,
		32'hffffff84, 32'hffffff8c};
	logic [31:0] sz [9][6] = '{'{32'h100, 32'h7c00, 0, 6, 32'h80000000, 0},
		'{32'h180, 32'h7c00, 0, 6, 32'h00000004, 0}, '{32'h180, 32'h7c00, 0, 7, 32'hffffffc0, 0},
		'{32'h800, 32'hc0000, 0, 7, 32'h80000000, 0}, '{32'h800, 32'hb8000, 0, 7, 32'hc0000000, 0},
		'{32'h20000, 32'h3e000000, 0, 9, 32'h80000000, 0}, '{32'h20, 32'h300, 0, 5, 32'h80000000, 0},
		'{32'h4, 32'h0, 32'h10000, 4, 32'hfffffff0, 0},
		'{32'h1, 32'h0, 32'h10000, 4, 32'hfffffffd, 0}};
	pcthb_header_bank dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
		.cfgDone(cfgDone), .probe(probe), .probeHit(probeHit), .probeHitValid(probeHitValid));
	pcthb_root_model rc (.mclk(mclk), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
		.cfgDone(cfgDone), .probe(probe), .probeHit(probeHit), .probeHitValid(probeHitValid));
	initial
	begin
		forever #20 mclk = ~mclk;
	end
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// Sampled at the edge itself, so request and data hold until waitrequest is seen low
		do
		begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		`CHK(n < 50, 1'b1)
	endtask
	task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		logic [31:0] r;
		bus(1'b1, a, d, be, r);
	endtask
	task automatic ar(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, 4'hf, r);
		`CHK(r, e)
	endtask
	task automatic cw(input logic [3:0] dw, input logic [31:0] d);
		logic [31:0] r;
		logic done;
		rc.cfg(1'b1, 1'b0, dw, d, r, done);
		`CHK(done, 1'b1)
	endtask
	task automatic cr(input logic vf, input logic [3:0] dw, input logic [31:0] e);
		logic [31:0] r;
		logic done;
		rc.cfg(1'b0, vf, dw, 32'h0, r, done);
		`CHK(done, 1'b1)
		`CHK(r, e)
	endtask
	task automatic pr(input logic isMem, input logic [63:0] a, input logic [6:0] e);
		logic [6:0] h;
		logic hv;
		rc.look(isMem, a, h, hv);
		`CHK(hv, 1'b1)
		`CHK(h, e)
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		// Whole run is a few hundred cycles; generous margin
		repeat (20000) @(posedge mclk);
		mismatches++;
		test_done;
	end
	initial
	begin
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		ar(8'h04, 32'h0000ff00);
		ar(8'h1c, 32'h0);
		ar(8'h40, 32'h0);
		$display("reset test done");
		aw(8'h00, 32'h1234abcd, 4'h1);
		ar(8'h00, 32'h000000cd);
		aw(8'h00, 32'h1234abcd);
		cr(1'b0, 4'hb, 32'habcd0000);
		cr(1'b1, 4'hb, 32'habcd0000);
		for (int p = 0; p < 8; p++)
		begin
			aw(8'h04, 32'h00000a00 | p);
			cr(1'b0, 4'hf, {16'h0, p < 5 ? p[7:0] : 8'h00, 8'h0a});
		end
		cr(1'b1, 4'hf, 32'h0);
		aw(8'h08, 32'h000000a5);
		cr(1'b0, 4'h3, 32'ha5000000);
		cr(1'b1, 4'h3, 32'h0);
		aw(8'h0c, 32'h00005040);
		cr(1'b0, 4'hd, 32'h40);
		cr(1'b1, 4'hd, 32'h50);
		$display("header test done");
		for (int t = 0; t < 8; t++)
		begin
			aw(8'h10, t);
			cw(4'h4, 32'hffffffff);
			cr(1'b0, 4'h4, wt[t]);
			cw(4'h5, 32'hffffffff);
			cr(1'b0, 4'h5, t > 5 ? 32'hffffffff : 32'h0);
		end
		aw(8'h10, 32'h0000000e);
		cr(1'b0, 4'h5, 32'hffffffff);
		aw(8'h10, 32'h0000000c);
		cw(4'h5, 32'hffffffff);
		cr(1'b0, 4'h5, 32'hffffff81);
		aw(8'h10, 32'h00000034);
		cr(1'b0, 4'h5, 32'h0);
		for (int i = 0; i < 9; i++)
		begin
			aw(8'h10, sz[i][0]);
			aw(8'h14, sz[i][1]);
			aw(8'h18, sz[i][2]);
			cw(sz[i][3][3:0], 32'hffffffff);
			cr(1'b0, sz[i][3][3:0], sz[i][4]);
		end
		$display("window test done");
		aw(8'h18, 32'h0);
		aw(8'h10, 32'h4);
		aw(8'h14, 32'h0);
		cw(4'h4, 32'hffffffff);
		pr(1'b1, 64'hffffff90, 7'h01);
		pr(1'b0, 64'hffffff90, 7'h00);
		pr(1'b1, 64'h1ffffff90, 7'h00);
		ar(8'h1c, 32'h00000100);
		aw(8'h10, 32'h0);
		pr(1'b1, 64'hffffff90, 7'h00);
		cw(4'hc, 32'hffffffff);
		cr(1'b0, 4'hc, 32'h0);
		aw(8'h18, 32'h1);
		cw(4'hc, 32'hffffffff);
		cr(1'b0, 4'hc, 32'hfffff801);
		pr(1'b1, 64'hfffff900, 7'h40);
		aw(8'h18, 32'h0);
		pr(1'b1, 64'hfffff900, 7'h00);
		cr(1'b0, 4'hc, 32'h0);
		$display("claim test done");
		test_done;
	end
endmodule

// file: pcthb_pkg.sv
package pcthb_pkg;
	typedef enum logic [2:0] {
		PCTHB_OFF = 3'h0,
		PCTHB_IO = 3'h1,
		PCTHB_RSV2 = 3'h2,
		PCTHB_RSV3 = 3'h3,
		PCTHB_MEM32 = 3'h4,
		PCTHB_MEM32P = 3'h5,
		PCTHB_MEM64 = 3'h6,
		PCTHB_MEM64P = 3'h7
	} pcthb_wtype_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic virtualFn;
		logic [3:0] dword;
		logic [3:0] byteEn;
		logic [31:0] data;
	} pcthb_cfgreq_s;

	typedef struct packed {
		logic valid;
		logic isMem;
		logic [63:0] addr;
	} pcthb_probe_s;

	localparam int PCTHB_NUM_PAIRS = 3;
	localparam int PCTHB_NUM_WIN = 6;
	localparam int PCTHB_TYPE_W = 3;
	localparam int PCTHB_SIZE_W = 5;

	// Aperture exponents: log2 of the byte size at code zero, then the 32 and 64 bit exponent caps
	localparam logic [5:0] PCTHB_EP_BASE_EXP = 6'h07;
	localparam logic [5:0] PCTHB_RP_BASE_EXP = 6'h02;
	localparam logic [5:0] PCTHB_ROM_BASE_EXP = 6'h0b;
	localparam logic [5:0] PCTHB_EXP32_MAX = 6'h1f;
	localparam logic [5:0] PCTHB_EXP64_MAX = 6'h3f;
	localparam logic [4:0] PCTHB_ODD_CODE_MAX = 5'h18;
	localparam logic [2:0] PCTHB_PIN_MAX = 3'h4;

	localparam logic [7:0] PCTHB_CAP_PTR_OFFSET = 8'h34;
	localparam logic [3:0] PCTHB_DW_BIST = 4'h3;
	localparam logic [3:0] PCTHB_DW_BAR0 = 4'h4;
	localparam logic [3:0] PCTHB_DW_BAR5 = 4'h9;
	localparam logic [3:0] PCTHB_DW_SUBSYS = 4'hb;
	localparam logic [3:0] PCTHB_DW_ROM = 4'hc;
	localparam logic [3:0] PCTHB_DW_CAP = PCTHB_CAP_PTR_OFFSET[5:2];
	localparam logic [3:0] PCTHB_DW_INT = 4'hf;
	localparam int PCTHB_BIST_LSB = 24;
	localparam int PCTHB_SUBSYS_LSB = 16;
	localparam int PCTHB_PIN_LSB = 8;

	localparam logic [31:0] PCTHB_IO_ATTR = 32'h00000001;
	localparam logic [31:0] PCTHB_TYPE64_ATTR = 32'h00000004;
	localparam logic [31:0] PCTHB_PREF_ATTR = 32'h00000008;
	localparam logic [31:0] PCTHB_IO_LOW = 32'h00000003;
	localparam logic [31:0] PCTHB_MEM_LOW = 32'h0000000f;
	localparam logic [31:0] PCTHB_ROM_EN_BIT = 32'h00000001;

	localparam logic [7:0] PCTHB_AV_SUBSYS = 8'h00;
	localparam logic [7:0] PCTHB_AV_IRQ = 8'h04;
	localparam logic [7:0] PCTHB_AV_BIST = 8'h08;
	localparam logic [7:0] PCTHB_AV_CAP = 8'h0c;
	localparam logic [7:0] PCTHB_AV_TYPE = 8'h10;
	localparam logic [7:0] PCTHB_AV_SIZE = 8'h14;
	localparam logic [7:0] PCTHB_AV_MODE = 8'h18;
	localparam logic [7:0] PCTHB_AV_STATUS = 8'h1c;
	localparam int PCTHB_NUM_SET = 7;
	localparam logic [2:0] PCTHB_IX_SUBSYS = 3'h0;
	localparam logic [2:0] PCTHB_IX_IRQ = 3'h1;
	localparam logic [2:0] PCTHB_IX_BIST = 3'h2;
	localparam logic [2:0] PCTHB_IX_CAP = 3'h3;
	localparam logic [2:0] PCTHB_IX_TYPE = 3'h4;
	localparam logic [2:0] PCTHB_IX_SIZE = 3'h5;
	localparam logic [2:0] PCTHB_IX_MODE = 3'h6;
	localparam int PCTHB_LINE_LSB = 8;
	localparam int PCTHB_VFCAP_LSB = 8;
	localparam int PCTHB_ROMSIZE_LSB = 8;
	localparam int PCTHB_ROOT_LSB = 16;
	localparam int PCTHB_COUNT_LSB = 8;
	localparam logic [31:0] PCTHB_IMPL [PCTHB_NUM_SET] = '{32'h0000ffff, 32'h0000ff07,
		32'h000000ff, 32'h0000ffff, 32'h0003ffff, 32'h3fffffff, 32'h00011f01};
	localparam logic [31:0] PCTHB_RST [PCTHB_NUM_SET] = '{32'h0, 32'h0000ff00,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (data & m);
	endfunction

	function automatic logic [5:0] sizeExp(input logic [4:0] code, input logic [5:0] base,
		input logic [5:0] top);
		logic [6:0] e;
		e = {2'b00, code} + {1'b0, base};
		return (e > {1'b0, top}) ? top : e[5:0];
	endfunction
endpackage

// file: pcthb_rom_window.sv
`timescale 1ns/1ns
module pcthb_rom_window (
	input logic mclk,
	input logic rst_b,
	input logic enable,
	input logic [4:0] sizeCode,
	input logic wr,
	input logic [31:0] wrData,
	input logic [3:0] byteEn,
	output logic [31:0] value,
	input pcthb_pkg::pcthb_probe_s probe,
	output logic hit
);
	logic [31:0] sizeMask, keep, base;

	assign sizeMask = {32{1'b1}} << pcthb_pkg::sizeExp(sizeCode, pcthb_pkg::PCTHB_ROM_BASE_EXP,
		pcthb_pkg::PCTHB_EXP32_MAX);
	assign keep = sizeMask | pcthb_pkg::PCTHB_ROM_EN_BIT;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			base <= 32'h0;
		else if (wr && enable)
			base <= pcthb_pkg::byteMerge(base, wrData, byteEn) & keep;
	end

	assign value = enable ? (base & keep) : 32'h0;
	// Decoding needs both the build setting and the host's own decode bit
	assign hit = probe.valid & probe.isMem & enable &
		((base & pcthb_pkg::PCTHB_ROM_EN_BIT) != 32'h0) & (probe.addr[63:32] == 32'h0) &
		((probe.addr[31:0] & sizeMask) == (base & sizeMask));
endmodule

// file: pcthb_root_model.sv
`timescale 1ns/1ns
module pcthb_root_model (
	input logic mclk,
	output pcthb_pkg::pcthb_cfgreq_s cfgReq,
	input logic [31:0] cfgRdData,
	input logic cfgDone,
	output pcthb_pkg::pcthb_probe_s probe,
	input logic [6:0] probeHit,
	input logic probeHitValid
);
	initial
	begin
		cfgReq = '0;
		probe = '0;
	end
	// Released fields are inverted so a stale request never looks live
	task automatic cfg(input logic wr, input logic vf, input logic [3:0] dw,
		input logic [31:0] d, output logic [31:0] rd, output logic done);
		@(posedge mclk);
		cfgReq <= '{1'b1, wr, vf, dw, 4'hf, d};
		@(posedge mclk);
		cfgReq <= '{1'b0, ~wr, ~vf, ~dw, 4'h0, ~d};
		#1;
		rd = cfgRdData;
		done = cfgDone;
	endtask
	task automatic look(input logic isMem, input logic [63:0] a, output logic [6:0] hit,
		output logic hv);
		@(posedge mclk);
		probe <= '{1'b1, isMem, a};
		@(posedge mclk);
		probe <= '{1'b0, ~isMem, ~a};
		#1;
		hit = probeHit;
		hv = probeHitValid;
	endtask
endmodule

// file: pcthb_window_pair.sv
`timescale 1ns/1ns
module pcthb_window_pair (
	input logic mclk,
	input logic rst_b,
	input logic rootPort,
	input logic [2:0] loType,
	input logic [2:0] hiType,
	input logic [4:0] loSize,
	input logic [4:0] hiSize,
	input logic wrLo,
	input logic wrHi,
	input logic [31:0] wrData,
	input logic [3:0] byteEn,
	output logic [31:0] loValue,
	output logic [31:0] hiValue,
	input pcthb_pkg::pcthb_probe_s probe,
	output logic hitLo,
	output logic hitHi
);
	logic paired, loOn, hiOn, allOnes;
	logic [4:0] hiCode;
	logic [5:0] loExp, hiExp;
	logic [63:0] pairMask;
	logic [31:0] loSizeMask, hiSizeMask, loBase, hiBase;

	function automatic logic [31:0] attrOf(input logic [2:0] t);
		logic [31:0] a;
		a = 32'h0;
		if (t == pcthb_pkg::PCTHB_IO)
			a = pcthb_pkg::PCTHB_IO_ATTR;
		else if (t[2])
		begin
			if (t[1])
				a = a | pcthb_pkg::PCTHB_TYPE64_ATTR;
			if (t[0])
				a = a | pcthb_pkg::PCTHB_PREF_ATTR;
		end
		return a;
	endfunction

	function automatic logic [31:0] lowOf(input logic [2:0] t);
		return (t == pcthb_pkg::PCTHB_IO) ? pcthb_pkg::PCTHB_IO_LOW : pcthb_pkg::PCTHB_MEM_LOW;
	endfunction

	assign paired = loType[2] & loType[1];
	assign loOn = (loType == pcthb_pkg::PCTHB_IO) | loType[2];
	// Odd codes 110 and 111 are undefined for an odd window, so they disable it
	assign hiOn = ~paired & ((hiType == pcthb_pkg::PCTHB_IO) | (hiType[2] & ~hiType[1]));
	assign hiCode = (hiSize > pcthb_pkg::PCTHB_ODD_CODE_MAX) ? pcthb_pkg::PCTHB_ODD_CODE_MAX : hiSize;
	assign loExp = pcthb_pkg::sizeExp(loSize, rootPort ? pcthb_pkg::PCTHB_RP_BASE_EXP :
		pcthb_pkg::PCTHB_EP_BASE_EXP, paired ? pcthb_pkg::PCTHB_EXP64_MAX :
		pcthb_pkg::PCTHB_EXP32_MAX);
	assign hiExp = pcthb_pkg::sizeExp(hiCode, pcthb_pkg::PCTHB_EP_BASE_EXP,
		pcthb_pkg::PCTHB_EXP32_MAX);
	assign pairMask = {64{1'b1}} << loExp;
	assign loSizeMask = pairMask[31:0] & ~lowOf(loType);
	assign hiSizeMask = paired ? pairMask[63:32] : (({32{1'b1}} << hiExp) & ~lowOf(hiType));

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			loBase <= 32'h0;
		else if (wrLo && loOn)
			loBase <= pcthb_pkg::byteMerge(loBase, wrData, byteEn) & loSizeMask;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			hiBase <= 32'h0;
		else if (wrHi && (paired || hiOn))
			hiBase <= pcthb_pkg::byteMerge(hiBase, wrData, byteEn) & hiSizeMask;
	end

	assign loValue = loOn ? ((loBase & loSizeMask) | attrOf(loType)) : 32'h0;
	assign hiValue = paired ? (hiBase & hiSizeMask) :
		hiOn ? ((hiBase & hiSizeMask) | attrOf(hiType)) : 32'h0;

	// A pair decodes all 64 address bits; single windows demand a zero upper half
	assign hitLo = probe.valid & loOn & (probe.isMem == loType[2]) & (paired ?
		((probe.addr & {hiSizeMask, loSizeMask}) == ({hiBase, loBase} & {hiSizeMask, loSizeMask})) :
		((probe.addr[63:32] == 32'h0) &&
		((probe.addr[31:0] & loSizeMask) == (loBase & loSizeMask))));
	assign hitHi = probe.valid & hiOn & (probe.isMem == hiType[2]) &
		(probe.addr[63:32] == 32'h0) &
		((probe.addr[31:0] & hiSizeMask) == (hiBase & hiSizeMask));

	assign allOnes = (wrData == 32'hffffffff) && (byteEn == 4'hf);

	off_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(!loOn |-> loValue == 32'h0 && !hitLo) and (!paired && !hiOn |-> hiValue == 32'h0 && !hitHi))
		else $error("disabled window reads or claims");
	upper_half_a: assert property (@(posedge mclk) disable iff (!rst_b)
		paired && $past(paired) && $changed(hiType) && !$past(wrHi) |-> $stable(hiValue) && !hitHi)
		else $error("upper half obeys its own control code");
	type_attr_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(loType == pcthb_pkg::PCTHB_IO |-> loValue[1:0] == 2'b01) and
		(paired |-> loValue[2:0] == 3'b100 && loValue[3] == loType[0]))
		else $error("window type bits wrong");
	size_lo_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wrLo && allOnes && !rootPort && loType == pcthb_pkg::PCTHB_MEM32 && loSize == 5'h00)
		##1 ($stable(loType) && $stable(loSize) && $stable(rootPort)) |-> loValue == 32'hffffff80)
		else $error("128 byte window sizes wrong");
	size_pair_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wrHi && allOnes && paired && !rootPort && loSize == 5'h1f)
		##1 ($stable(loType) && $stable(loSize) && $stable(rootPort)) |-> hiValue == 32'hffffffc0)
		else $error("256 Gbyte pair sizes wrong");
	size_odd_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wrHi && allOnes && !paired && hiType == pcthb_pkg::PCTHB_MEM32 && hiSize == 5'h18)
		##1 ($stable(hiType) && $stable(hiSize) && $stable(loType)) |-> hiValue == 32'h80000000)
		else $error("2 Gbyte odd window sizes wrong");
	size_root_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wrLo && allOnes && rootPort && loType == pcthb_pkg::PCTHB_IO && loSize == 5'h00)
		##1 ($stable(loType) && $stable(loSize) && $stable(rootPort)) |-> loValue == 32'hfffffffd)
		else $error("4 byte root window sizes wrong");
endmodule
